/* src/sdram_burst_core.sv */
// Synchronous DRAM device core: command decode, burst ordering, masks and clock suspend.
`timescale 1ns/10ps

// ============================================================================
// Write beat buffer between the data pins and the storage array
module sdram_beat_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstN,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] slots [DEPTH];
  logic [AW-1:0]    wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
  logic [AW:0]      count_reg, count_next;
  logic             push, pop;

  assign inReady  = (count_reg != (AW+1)'(DEPTH));
  assign outValid = (count_reg != '0);
  assign outData  = slots[rdPtr_reg];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_comb begin
    wrPtr_next = push ? AW'((wrPtr_reg + 1'b1) % DEPTH) : wrPtr_reg;
    rdPtr_next = pop ? AW'((rdPtr_reg + 1'b1) % DEPTH) : rdPtr_reg;
    count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      wrPtr_reg <= wrPtr_next;
      rdPtr_reg <= rdPtr_next;
      count_reg <= count_next;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      slots[wrPtr_reg] <= inData;
    end
  end
endmodule

module sdram_burst_core
  import sdram_timing_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // Command pins, sampled on the rising edge
  input  wire logic              cke,
  input  wire cmd_pins_type      cmdPins,
  input  wire logic              dqm,
  // Data pins
  input  wire logic [DATA_W-1:0] dqIn,
  output logic [DATA_W-1:0]      dqOut,
  output logic                   dqOe,
  // Status
  output logic                   suspended,
  output logic                   writeReady
);
  // ==========================================================================
  // Reset release
  logic rstMeta_reg, rstSync_reg;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end

  // ==========================================================================
  // State
  logic [DATA_W-1:0] store [STORE_WORDS];
  logic                   ckeDly_reg, ckeDly_next;
  logic [2:0]             modeBl_reg, modeBl_next, modeCl_reg, modeCl_next;
  logic                   modeIlv_reg, modeIlv_next;
  logic [STORE_ROW_W-1:0] rows_reg [4], rows_next [4];
  burst_state_type        burst_reg, burst_next;
  logic [BANK_W-1:0]      bank_reg, bank_next;
  logic [COL_W-1:0]       startCol_reg, startCol_next, beatIdx_reg, beatIdx_next;
  logic [1:0]             pipeValid_reg, pipeValid_next, dqmDly_reg, dqmDly_next;
  logic [DATA_W-1:0]      pipeData_reg [2], pipeData_next [2];
  logic [DATA_W-1:0]      dqOut_reg, dqOut_next;
  logic                   dqOe_reg, dqOe_next;

  logic              advance, taken, colCmd, endCmd, readNow, lastBeat, fullPage;
  cmd_code_type      code;
  logic [COL_W-1:0]  lowMask, beatCol, cmdCol;
  logic [DATA_W-1:0] memRead;
  wr_beat_type       inBeat, outBeat;
  logic              fifoInValid, fifoOutValid, fifoOutReady;

  function automatic logic [COL_W-1:0] colFor(input logic [COL_W-1:0] start,
                                              input logic [COL_W-1:0] idx,
                                              input logic [COL_W-1:0] mask,
                                              input logic             ilv);
    logic [COL_W-1:0] low;
    low = ilv ? (start ^ idx) : COL_W'(start + idx);
    return (start & ~mask) | (low & mask);
  endfunction

  // ==========================================================================
  // Decode and burst addressing
  always_comb begin
    case (modeBl_reg)
      BL_2:    lowMask = COL_W'(1);
      BL_4:    lowMask = COL_W'(3);
      BL_8:    lowMask = COL_W'(7);
      BL_FULL: lowMask = modeIlv_reg ? '0 : '1;
      default: lowMask = '0;
    endcase
  end

  // A held-low enable freezes the burst, mode and output state from the following edge on; buffered writes still drain into the array.
  assign advance   = ckeDly_reg;
  assign suspended = !ckeDly_reg;
  assign code      = cmd_code_type'({cmdPins.rasN, cmdPins.casN, cmdPins.weN});
  assign taken     = advance && !cmdPins.csN;
  assign colCmd    = taken && (code == CMD_READ || code == CMD_WRITE);
  assign endCmd    = taken && (code == CMD_STOP || (code == CMD_PRECHARGE &&
                     (cmdPins.addr[PRECHARGE_ALL] || cmdPins.ba == bank_reg)));
  assign cmdCol    = cmdPins.addr[COL_W-1:0];
  assign fullPage  = (modeBl_reg == BL_FULL) && !modeIlv_reg;
  assign beatCol   = colFor(startCol_reg, beatIdx_reg, lowMask, modeIlv_reg);
  assign lastBeat  = !fullPage && (beatIdx_reg == lowMask);
  assign readNow   = advance && burst_reg == BURST_READ;
  assign memRead   = store[{bank_reg, rows_reg[bank_reg], beatCol}];

  // ==========================================================================
  // Write path into the beat buffer
  always_comb begin
    inBeat      = '{where: {bank_reg, rows_reg[bank_reg], beatCol}, data: dqIn};
    fifoInValid = 1'b0;
    if (colCmd && code == CMD_WRITE) begin
      // First beat rides on the command edge itself.
      inBeat.where = {cmdPins.ba, rows_reg[cmdPins.ba], cmdCol};
      fifoInValid  = !dqm;
    end else if (advance && burst_reg == BURST_WRITE && !colCmd && !endCmd) begin
      fifoInValid = !dqm;
    end
  end

  // The array has one port, so buffered writes wait while a read beat is fetched.
  assign fifoOutReady = !readNow;

  sdram_beat_fifo #(
    .WIDTH ($bits(wr_beat_type)),
    .DEPTH (FIFO_DEPTH)
  ) beatFifo (
    .clk      (core_clk),
    .rstN     (rstSync_reg),
    .inValid  (fifoInValid),
    .inReady  (writeReady),
    .inData   (inBeat),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady),
    .outData  (outBeat)
  );

  always_ff @(posedge core_clk) begin
    if (fifoOutValid && fifoOutReady) begin
      store[outBeat.where] <= outBeat.data;
    end
  end

  // ==========================================================================
  // Next state
  always_comb begin
    ckeDly_next    = cke;
    modeBl_next    = modeBl_reg;
    modeCl_next    = modeCl_reg;
    modeIlv_next   = modeIlv_reg;
    rows_next      = rows_reg;
    burst_next     = burst_reg;
    bank_next      = bank_reg;
    startCol_next  = startCol_reg;
    beatIdx_next   = beatIdx_reg;
    pipeValid_next = pipeValid_reg;
    pipeData_next  = pipeData_reg;
    dqmDly_next    = dqmDly_reg;
    dqOut_next     = dqOut_reg;
    dqOe_next      = dqOe_reg;
    if (advance) begin
      if (taken && code == CMD_MODE) begin
        modeBl_next  = cmdPins.addr[MODE_BL_LSB +: 3];
        modeIlv_next = cmdPins.addr[MODE_BT_BIT];
        modeCl_next  = cmdPins.addr[MODE_CL_LSB +: 3];
      end
      if (taken && code == CMD_ACTIVATE) begin
        rows_next[cmdPins.ba] = cmdPins.addr[STORE_ROW_W-1:0];
      end
      if (colCmd) begin
        bank_next     = cmdPins.ba;
        startCol_next = cmdCol;
        if (code == CMD_WRITE) begin
          burst_next   = (lowMask == '0) ? BURST_IDLE : BURST_WRITE;
          beatIdx_next = COL_W'(1);
        end else begin
          burst_next   = BURST_READ;
          beatIdx_next = '0;
        end
      end else if (endCmd) begin
        burst_next = BURST_IDLE;
      end else if (burst_reg != BURST_IDLE) begin
        burst_next   = lastBeat ? BURST_IDLE : burst_reg;
        beatIdx_next = COL_W'(beatIdx_reg + 1'b1);
      end
      // The beat fetched on the stop edge itself is still delivered.
      pipeValid_next = {pipeValid_reg[0], readNow};
      pipeData_next  = '{memRead, pipeData_reg[0]};
      dqmDly_next    = {dqmDly_reg[0], dqm};
      dqOut_next     = (modeCl_reg == CL_3) ? pipeData_reg[1] : pipeData_reg[0];
      dqOe_next      = ((modeCl_reg == CL_3) ? pipeValid_reg[1] : pipeValid_reg[0])
                       && !dqmDly_reg[1];
    end
  end

  always_ff @(posedge core_clk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      ckeDly_reg    <= CKE_DLY_RESET;
      modeBl_reg    <= MODE_BL_RESET;
      modeCl_reg    <= MODE_CL_RESET;
      modeIlv_reg   <= MODE_BT_RESET;
      rows_reg      <= '{default: '0};
      burst_reg     <= BURST_IDLE;
      bank_reg      <= '0;
      startCol_reg  <= '0;
      beatIdx_reg   <= '0;
      pipeValid_reg <= '0;
      pipeData_reg  <= '{default: '0};
      dqmDly_reg    <= '0;
      dqOut_reg     <= '0;
      dqOe_reg      <= 1'b0;
    end else begin
      ckeDly_reg    <= ckeDly_next;
      modeBl_reg    <= modeBl_next;
      modeCl_reg    <= modeCl_next;
      modeIlv_reg   <= modeIlv_next;
      rows_reg      <= rows_next;
      burst_reg     <= burst_next;
      bank_reg      <= bank_next;
      startCol_reg  <= startCol_next;
      beatIdx_reg   <= beatIdx_next;
      pipeValid_reg <= pipeValid_next;
      pipeData_reg  <= pipeData_next;
      dqmDly_reg    <= dqmDly_next;
      dqOut_reg     <= dqOut_next;
      dqOe_reg      <= dqOe_next;
    end
  end

  assign dqOut = dqOut_reg;
  assign dqOe  = dqOe_reg;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstSync_reg);

  logic quietStep;
  assign quietStep = readNow && !lastBeat && !colCmd && !endCmd;

  a_mask_read_float: assert property ((advance && dqm) ##1 advance ##1 advance |=> !dqOe)
    else $error("output still driven two clocks after read mask");
  a_write_mask_drop: assert property ((colCmd && code == CMD_WRITE) |->
      (fifoInValid == !dqm) && inBeat.data == dqIn && inBeat.where[COL_W-1:0] == cmdCol)
    else $error("write command beat not captured as sampled");
  a_suspend_freeze: assert property (!ckeDly_reg |=> $stable(beatIdx_reg) && $stable(dqOe))
    else $error("state moved while clock suspended");
  a_suspend_entry: assert property ((ckeDly_reg && !cke) |=> suspended)
    else $error("suspend not entered one clock after enable low");
  a_suspend_exit: assert property ((!ckeDly_reg && cke) |=> !suspended)
    else $error("suspend not left one clock after enable high");
  a_stop_float_cl2: assert property ((endCmd && modeCl_reg == CL_2)
      ##1 (advance && !colCmd) [*2] |=> !dqOe)
    else $error("output not floated two clocks after stop at latency 2");
  a_stop_float_cl3: assert property ((endCmd && modeCl_reg == CL_3)
      ##1 (advance && !colCmd) [*3] |=> !dqOe)
    else $error("output not floated three clocks after stop at latency 3");
  a_seq_wrap_step: assert property ((quietStep && !modeIlv_reg) |=>
      (COL_W'(beatCol - $past(beatCol)) & lowMask) == COL_W'(1) &&
      (beatCol & ~lowMask) == ($past(beatCol) & ~lowMask))
    else $error("sequential burst column did not step with wrap");
  a_ilv_xor_step: assert property ((quietStep && modeIlv_reg) |=>
      ((beatCol ^ startCol_reg) & lowMask) == COL_W'($past(beatIdx_reg) + 1'b1))
    else $error("interleaved burst column is not start xor index");
  a_col_each_cycle: assert property (colCmd |=> startCol_reg == $past(cmdCol) &&
      bank_reg == $past(cmdPins.ba))
    else $error("column command not taken on its own edge");

  c_read_burst: cover property ((colCmd && code == CMD_READ) ##[1:12] dqOe);
  c_write_burst: cover property ((colCmd && code == CMD_WRITE) ##1 fifoInValid);
  c_suspend_cycle: cover property (suspended ##[1:8] !suspended);
  c_mask_float: cover property (dqOe ##1 dqm ##3 !dqOe);
endmodule

/* src/sdram_timing_pkg.sv */
// Shared constants, command codes and carrier types for the synchronous DRAM core.
package sdram_timing_pkg;

  // ==========================================================================
  // Widths and storage shape
  localparam int DATA_W      = 16;
  localparam int ADDR_W      = 12;
  localparam int BANK_W      = 2;
  localparam int COL_W       = 8;
  localparam int STORE_ROW_W = 2;
  localparam int STORE_AW    = BANK_W + STORE_ROW_W + COL_W;
  localparam int STORE_WORDS = 1 << STORE_AW;

  // ==========================================================================
  // Mode register fields and reset values
  localparam int MODE_BL_LSB   = 0;
  localparam int MODE_BT_BIT   = 3;
  localparam int MODE_CL_LSB   = 4;
  localparam int PRECHARGE_ALL = 10;
  localparam logic [2:0] BL_1    = 3'h0;
  localparam logic [2:0] BL_2    = 3'h1;
  localparam logic [2:0] BL_4    = 3'h2;
  localparam logic [2:0] BL_8    = 3'h3;
  localparam logic [2:0] BL_FULL = 3'h7;
  localparam logic [2:0] CL_2    = 3'h2;
  localparam logic [2:0] CL_3    = 3'h3;
  localparam logic [2:0] MODE_BL_RESET  = BL_1;
  localparam logic [2:0] MODE_CL_RESET  = CL_2;
  localparam logic       MODE_BT_RESET  = 1'b0;
  localparam logic       CKE_DLY_RESET  = 1'b0;

  // ==========================================================================
  // Timing counts in clocks on the device side
  localparam int MASK_TO_OUTPUT_FLOAT_CLK   = 2;
  localparam int CLOCK_DISABLE_LATENCY_CLK  = 1;
  localparam int CLOCK_REENABLE_LATENCY_CLK = 1;
  localparam int COLUMN_TO_COLUMN_GAP_CLK   = 1;

  // ==========================================================================
  // Commands, decoded from {row strobe, column strobe, write enable}, all low active
  typedef enum logic [2:0] {
    CMD_MODE      = 3'b000,
    CMD_REFRESH   = 3'b001,
    CMD_PRECHARGE = 3'b010,
    CMD_ACTIVATE  = 3'b011,
    CMD_WRITE     = 3'b100,
    CMD_READ      = 3'b101,
    CMD_STOP      = 3'b110,
    CMD_NOP       = 3'b111
  } cmd_code_type;

  typedef enum logic [1:0] {
    BURST_IDLE  = 2'b00,
    BURST_READ  = 2'b01,
    BURST_WRITE = 2'b10
  } burst_state_type;

  typedef struct packed {
    logic              csN;
    logic              rasN;
    logic              casN;
    logic              weN;
    logic [BANK_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
  } cmd_pins_type;

  typedef struct packed {
    logic [STORE_AW-1:0] where;
    logic [DATA_W-1:0]   data;
  } wr_beat_type;

endpackage

/* tb/sdram_ctl_model.sv */
// Memory controller model that drives the device's command, mask and data pins.
`timescale 1ns/10ps
module sdram_ctl_model
  import sdram_timing_pkg::*;
#(
  parameter int PERIOD_NS = 10
) (
  // Clock
  input  wire logic         core_clk,
  // Pins toward the device
  output logic              cke,
  output cmd_pins_type      cmdPins,
  output logic              dqm,
  output logic [DATA_W-1:0] dqIn
);
  // ==========================================================================
  // Gap in clocks; nanosecond minimums are rounded up to whole clocks.
  localparam int ACT_TO_COL = (20 + PERIOD_NS - 1) / PERIOD_NS;

  initial begin
    cke = 1'b1;
    cmdPins = {4'hf, 14'h0000};
    dqm = 1'b0;
    dqIn = 16'h0000;
  end

  // ==========================================================================
  // Bank 0 only, so activates never meet each other or an auto precharge.
  task automatic issue(input cmd_code_type c, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, input logic m);
    @(posedge core_clk);
    cmdPins <= {1'b0, c, 2'h0, a};
    dqIn <= d;
    dqm <= m;
  endtask

  // Idle data lines toggle so that a stale beat never looks valid.
  task automatic nop(input int n);
    repeat (n) begin
      @(posedge core_clk);
      cmdPins <= {4'hf, 14'h0000};
      dqIn <= ~dqIn;
      dqm <= 1'b0;
    end
  endtask

  task automatic mode(input logic [ADDR_W-1:0] a);
    issue(CMD_MODE, a, ~dqIn, 1'b0);
    nop(1);
  endtask

  task automatic activate();
    issue(CMD_ACTIVATE, 12'h000, ~dqIn, 1'b0);
    nop(ACT_TO_COL - 1);
  endtask

  task automatic set_cke(input logic v);
    @(posedge core_clk);
    cke <= v;
  endtask
endmodule

/* tb/sdram_command_timing_burst_order_test.sv */
// Self-checking bench for the synchronous DRAM core driven by a controller model.
`timescale 1ns/10ps
module sdram_command_timing_burst_order_test;
  import sdram_timing_pkg::*;

  // ==========================================================================
  // Signals
  logic              core_clk;
  logic              rst_n;
  logic              cke, dqm, dqOe, suspended, writeReady;
  cmd_pins_type      cmdPins;
  logic [DATA_W-1:0] dqIn, dqOut;
  logic [DATA_W-1:0] mem [8];
  logic [2:0]        startCol;
  int                err_count, cmp_count, bl, cl;

  sdram_burst_core #(.FIFO_DEPTH(16)) u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .cke(cke), .cmdPins(cmdPins), .dqm(dqm),
    .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe), .suspended(suspended),
    .writeReady(writeReady));

  sdram_ctl_model u_ctl (
    .core_clk(core_clk), .cke(cke), .cmdPins(cmdPins), .dqm(dqm), .dqIn(dqIn));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ==========================================================================
  // Helpers
  task automatic check(input string what, input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [2:0] exp_col(input logic [2:0] s, input int i, input int b,
                                         input logic ilv);
    logic [2:0] step, m;
    step = 3'(i);
    m    = 3'(b - 1);
    if (ilv) begin
      return s ^ step;
    end
    return (s & ~m) | (3'(s + step) & m);
  endfunction

  // One-column writes on consecutive clocks; masked beats keep the old word.
  task automatic write_all(input logic [7:0] maskBits);
    logic [DATA_W-1:0] d;
    for (int c = 0; c < 8; c++) begin
      d = DATA_W'($urandom);
      u_ctl.issue(CMD_WRITE, 12'(c), d, maskBits[c]);
      if (!maskBits[c]) begin
        mem[c] = d;
      end
    end
    u_ctl.nop(12);
  endtask

  // Read command on one clock, then an idle command slot.
  task automatic read_cmd(input logic [ADDR_W-1:0] a);
    u_ctl.issue(CMD_READ, a, ~dqIn, 1'b0);
    u_ctl.nop(1);
  endtask

  task automatic read_burst(input logic [2:0] s, input logic ilv);
    read_cmd(12'(s));
    repeat (cl) @(posedge core_clk);
    #1;
    for (int i = 0; i < bl; i++) begin
      check("dqOe", DATA_W'(dqOe), DATA_W'(1));
      check("dqOut", dqOut, mem[exp_col(s, i, bl, ilv)]);
      @(posedge core_clk);
      #1;
    end
    check("dqOe end", DATA_W'(dqOe), DATA_W'(0));
  endtask

  // Output enable is sampled after each of the next n edges; with drop set it falls after the last.
  task automatic float_check(input int n, input logic drop);
    for (int j = 1; j <= n; j++) begin
      @(posedge core_clk);
      #1;
      check("dqOe float", DATA_W'(dqOe), DATA_W'(j < n || !drop));
    end
    u_ctl.nop(8);
  endtask

  task automatic results();
    $display("comparisons %0d, errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge core_clk);
    err_count++;
    results();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    err_count = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    void'($urandom(32'h49581944));
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    u_ctl.nop(4);
    u_ctl.mode(12'h020);
    u_ctl.activate();
    write_all(8'h00);
    write_all(8'h01 << ($urandom % 8));
    check("writeReady", DATA_W'(writeReady), DATA_W'(1));
    // Every pairing of burst length 2, 4 or 8, latency 2 or 3 and both burst orders.
    for (int k = 0; k < 12; k++) begin
      bl = 2 << (k % 3);
      cl = 2 + ((k / 3) % 2);
      u_ctl.mode({5'h00, 3'(cl), 1'((k / 6) % 2), 3'((k % 3) + 1)});
      read_burst(3'($urandom), 1'((k / 6) % 2));
    end
    // Full-page reads cut by a burst stop or by a precharge of the open bank.
    for (int k = 0; k < 4; k++) begin
      cl = 2 + (k % 2);
      u_ctl.mode({5'h00, 3'(cl), 1'b0, BL_FULL});
      read_cmd(12'($urandom % 8));
      u_ctl.issue(k[1] ? CMD_PRECHARGE : CMD_STOP, 12'($urandom), ~dqIn, 1'b0);
      u_ctl.nop(1);
      float_check(cl, 1'b1);
      if (k[1]) begin
        u_ctl.activate();
      end
    end
    // Mask raised in mid-burst, once low and once high.
    u_ctl.mode(12'h023);
    for (int j = 0; j < 2; j++) begin
      read_cmd(12'($urandom % 8));
      u_ctl.nop(2);
      u_ctl.issue(CMD_NOP, 12'($urandom), ~dqIn, 1'(j));
      u_ctl.nop(1);
      float_check(2, 1'(j));
    end
    startCol = 3'($urandom);
    read_cmd(12'(startCol));
    repeat (2) @(posedge core_clk);
    u_ctl.set_cke(!cke);
    @(posedge core_clk);
    #1;
    check("dqOut last", dqOut, mem[exp_col(startCol, 2, 8, 1'b0)]);
    @(posedge core_clk);
    #1;
    check("suspended", DATA_W'(suspended), DATA_W'(1));
    check("dqOut frozen", dqOut, mem[exp_col(startCol, 2, 8, 1'b0)]);
    u_ctl.set_cke(!cke);
    @(posedge core_clk);
    #1;
    check("dqOut held", dqOut, mem[exp_col(startCol, 2, 8, 1'b0)]);
    @(posedge core_clk);
    #1;
    check("suspended", DATA_W'(suspended), DATA_W'(0));
    check("dqOut resumed", dqOut, mem[exp_col(startCol, 3, 8, 1'b0)]);
    u_ctl.nop(10);
    results();
  end
endmodule
